// ---- hdl/lintmc_top.sv ----
// mode control and supervisory logic of a lin transceiver with regulator
// Summary of operation
// [R1] operate request high means normal mode, transmit and receive paths active
// [R2] normal mode: low tx drives bus dominant, high tx leaves driver off
// [R3] tx low beyond dominant timeout forces driver recessive
// [R4] driver re-enabled only after tx held high over rearm time
// [R5] normal mode: rx output follows bus level
// [R6] request falling with tx high through select window gives silent mode
// [R7] request falling with tx low through select window gives sleep mode
// [R8] sleep: regulator off, reset output and rx output low
// [R9] request may fall up to lead time before tx; bus stays undisturbed
// [R10] silent or sleep: filtered dominant pulse on bus wakes to fail-safe
// [R11] after wake rx held low; wake from sleep turns regulator on
// [R12] from silent or fail-safe after wake, request high enters normal
// [R13] from sleep request high goes fail-safe, then normal after hold
// [R14] regulator undervoltage in normal or silent: reset low, fail-safe
// [R15] regulator undervoltage drives reset low after debounce delay
// [R16] reset held low for hold time after regulator reaches nominal
// [R17] fail-safe: bus off, regulator on, leave to normal on request
// [R18] battery collapse in silent or sleep restarts in fail-safe
// [R19] reset output low forces fail-safe from any mode; the code exempts sleep, where reset is held low
// [R20] battery above threshold leaves unpowered for fail-safe, requests ignored during hold
// [R21] battery undervoltage disables transmission
// [R22] fail-safe and silent: bus recessive, rx high except after wake
// [R23] debounce delay lies within its allowed range
// [R24] all intervals measured by counters on the internal clock
// [R25] wake indication stays until fail-safe is left for normal; the code also clears it in unpowered
`timescale 1ns/1ps
module lintmc_top #(
  parameter int DOM_CYCLES = lintmc_pkg::DOM_CYC,
  parameter int WAKE_CYCLES = lintmc_pkg::WAKE_CYC,
  parameter int HOLD_CYCLES = lintmc_pkg::RESET_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic op_req,
  input wire logic tx_bit_in,
  input wire logic bus_in,
  input wire logic vcc_uv,
  input wire logic vcc_good,
  input wire logic battery_off,
  input wire logic battery_uv,
  output logic bus_out,
  output logic bus_oe,
  output logic rx_bit_out,
  output logic reset_out_n,
  output logic regulator_en
);
  import lintmc_pkg::*;

  lintmc_stream_if s ();
  lintmc_state_t state;
  lintmc_state_t next_state;
  logic [WORD_W-1:0] sync_a;
  logic [WORD_W-1:0] sync_b;
  logic [WORD_W-1:0] src_word;
  logic src_valid;
  logic [WORD_W-1:0] cur;
  logic stall;
  logic take;
  logic opr;
  logic txl;
  logic busl;
  logic vuv;
  logic vgood;
  logic boff;
  logic buv;
  logic opr_d;
  logic op_fall;
  logic [CNT_W-1:0] dom_cnt;
  logic [CNT_W-1:0] hi_cnt;
  logic dom_lock;
  logic [CNT_W-1:0] sel_cnt;
  logic sel_done;
  logic [CNT_W-1:0] wk_cnt;
  logic wk_seen_hi;
  logic wake_pulse;
  logic wake_ind;
  logic [CNT_W-1:0] uv_cnt;
  logic uv_trip;
  logic [CNT_W-1:0] hold_cnt;
  logic hold_done;
  logic next_bus_oe;
  logic next_rx;
  logic next_reset_n;
  logic next_reg;

  // pins are asynchronous to mclk
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= PIN_RST;
      sync_b <= PIN_RST;
    end else begin
      sync_a <= {battery_uv, battery_off, vcc_good, vcc_uv, bus_in, tx_bit_in, op_req};
      sync_b <= sync_a;
    end
  end

  // sampler holds its word while the buffer is full; pin samples arriving meanwhile are dropped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      src_word <= PIN_RST;
      src_valid <= 1'b0;
    end else begin
      if (!src_valid || s.in_ready) begin
        src_word <= sync_b;
      end
      src_valid <= 1'b1;
    end
  end

  assign s.in_data = src_word;
  assign s.in_valid = src_valid;
  assign s.out_ready = !stall;
  assign take = s.out_valid && s.out_ready;

  lintmc_buffer u_buffer (
    .mclk(mclk),
    .resetn(resetn),
    .s(s)
  );

  // mode logic pauses intake one cycle after each mode change
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cur <= PIN_RST;
      stall <= 1'b0;
    end else begin
      if (take) begin
        cur <= s.out_data;
      end
      stall <= (next_state != state);
    end
  end

  assign opr = cur[F_OPREQ];
  assign txl = cur[F_TX];
  assign busl = cur[F_BUS];
  assign vuv = cur[F_VCC_UV];
  assign vgood = cur[F_VCC_GOOD];
  assign boff = cur[F_BAT_OFF];
  assign buv = cur[F_BAT_UV];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opr_d <= 1'b0;
    end else begin
      opr_d <= opr;
    end
  end

  assign op_fall = opr_d && !opr;

  // dominant timeout and rearm
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dom_cnt <= '0;
      hi_cnt <= '0;
      dom_lock <= 1'b0;
    end else begin
      if (state == ST_NORMAL && !txl) begin
        if (dom_cnt < CNT_W'(DOM_CYCLES)) begin
          dom_cnt <= CNT_W'(dom_cnt + 1'b1); // R24
        end else begin
          dom_lock <= 1'b1; // R3
        end
      end else begin
        dom_cnt <= '0;
      end
      if (txl && dom_lock) begin
        if (hi_cnt < CNT_W'(TX_REARM_CYC)) begin
          hi_cnt <= CNT_W'(hi_cnt + 1'b1);
        end else begin
          dom_lock <= 1'b0; // R4
          hi_cnt <= '0;
        end
      end else begin
        hi_cnt <= '0;
      end
    end
  end

  // select window is longer than the allowed request-to-tx lead
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_cnt <= '0;
    end else if (state == ST_SELECT) begin
      sel_cnt <= CNT_W'(sel_cnt + 1'b1); // R9
    end else begin
      sel_cnt <= '0;
    end
  end

  assign sel_done = (sel_cnt >= CNT_W'(MODE_WIN_CYC));

  // wake filter needs a recessive level first, so a stuck bus never wakes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wk_cnt <= '0;
      wk_seen_hi <= 1'b0;
    end else if (state == ST_SILENT || state == ST_SLEEP) begin
      if (busl) begin
        wk_seen_hi <= 1'b1;
        wk_cnt <= '0;
      end else if (wk_seen_hi && wk_cnt < CNT_W'(WAKE_CYCLES)) begin
        wk_cnt <= CNT_W'(wk_cnt + 1'b1); // R10
      end
    end else begin
      wk_cnt <= '0;
      wk_seen_hi <= 1'b0;
    end
  end

  assign wake_pulse = (state == ST_SILENT || state == ST_SLEEP) && busl &&
                      (wk_cnt >= CNT_W'(WAKE_CYCLES)); // R10

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_ind <= 1'b0;
    end else if (wake_pulse) begin
      wake_ind <= 1'b1; // R11
    end else if (state == ST_FAILSAFE && next_state == ST_NORMAL) begin
      wake_ind <= 1'b0; // R25
    end else if (state == ST_UNPOWERED) begin
      wake_ind <= 1'b0;
    end
  end

  // regulator undervoltage debounce and reset hold
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      uv_cnt <= '0;
    end else if (vuv && regulator_en) begin
      if (!uv_trip) begin
        uv_cnt <= CNT_W'(uv_cnt + 1'b1); // R15 R23
      end
    end else begin
      uv_cnt <= '0;
    end
  end

  assign uv_trip = (uv_cnt >= CNT_W'(UV_DEBOUNCE_CYC)); // R23

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= '0;
    end else if (!regulator_en || uv_trip || !vgood) begin
      hold_cnt <= '0;
    end else if (!hold_done) begin
      hold_cnt <= CNT_W'(hold_cnt + 1'b1); // R16 R24
    end
  end

  assign hold_done = (hold_cnt >= CNT_W'(HOLD_CYCLES));

  // mode state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_UNPOWERED: begin
        next_state = ST_FAILSAFE; // R20
      end
      ST_FAILSAFE: begin
        if (reset_out_n && opr) begin
          next_state = ST_NORMAL; // R12 R13 R17 R20
        end
      end
      ST_NORMAL: begin
        if (!reset_out_n) begin
          next_state = ST_FAILSAFE; // R14 R19
        end else if (op_fall) begin
          next_state = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (!reset_out_n) begin
          next_state = ST_FAILSAFE; // R19
        end else if (opr) begin
          next_state = ST_NORMAL; // R1
        end else if (sel_done) begin
          next_state = txl ? ST_SILENT : ST_SLEEP; // R6 R7
        end
      end
      ST_SILENT: begin
        if (!reset_out_n || wake_pulse) begin
          next_state = ST_FAILSAFE; // R14 R10
        end else if (opr) begin
          next_state = ST_NORMAL; // R12
        end
      end
      ST_SLEEP: begin
        // reset output is low by design here, so it cannot force fail-safe
        if (wake_pulse || opr) begin
          next_state = ST_FAILSAFE; // R10 R13
        end
      end
      default: begin
        next_state = ST_FAILSAFE;
      end
    endcase
    if (boff) begin
      next_state = ST_UNPOWERED; // R18
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_UNPOWERED;
    end else begin
      state <= next_state;
    end
  end

  // output decode
  always_comb begin
    next_bus_oe = (state == ST_NORMAL) && !txl && !dom_lock && !buv; // R2 R3 R21 R22
    next_reg = (state != ST_SLEEP) && (state != ST_UNPOWERED); // R8 R11 R17
    next_reset_n = hold_done && !uv_trip && next_reg; // R15 R16 R8
    case (state)
      ST_NORMAL: next_rx = busl; // R5
      ST_SELECT: next_rx = busl;
      ST_SLEEP: next_rx = 1'b0; // R8
      ST_FAILSAFE: next_rx = !wake_ind; // R11 R22
      default: next_rx = 1'b1; // R22
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_out <= 1'b0;
      bus_oe <= 1'b0;
      rx_bit_out <= 1'b1;
      reset_out_n <= 1'b0;
      regulator_en <= 1'b0;
    end else begin
      bus_out <= 1'b0;
      bus_oe <= next_bus_oe;
      rx_bit_out <= next_rx;
      reset_out_n <= next_reset_n;
      regulator_en <= next_reg;
    end
  end

  tx_high_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    txl |=> !bus_oe) else $error("bus driven while tx high");
  not_normal_a: assert property (@(posedge mclk) disable iff (!resetn) // R22
    (state != ST_NORMAL) |=> !bus_oe) else $error("bus driven outside normal mode");
  dom_lock_a: assert property (@(posedge mclk) disable iff (!resetn) // R3
    (dom_lock && !$past(dom_lock)) |-> !$past(txl) && $past(state) == ST_NORMAL) else $error("lock without dominant");
  rx_follow_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    (state == ST_NORMAL) |=> rx_bit_out == $past(busl)) else $error("rx not following bus");
  sleep_out_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    (state == ST_SLEEP) |=> !rx_bit_out && !reset_out_n && !regulator_en) else $error("sleep outputs wrong");
  wake_enter_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
    (wake_pulse && !boff) |=> state == ST_FAILSAFE && wake_ind) else $error("wake not taken");
  wake_rx_a: assert property (@(posedge mclk) disable iff (!resetn) // R11
    (state == ST_FAILSAFE && wake_ind) |=> !rx_bit_out) else $error("wake not shown on rx");
  reset_force_a: assert property (@(posedge mclk) disable iff (!resetn) // R19
    (!reset_out_n && !boff && (state == ST_NORMAL || state == ST_SILENT)) |=> state == ST_FAILSAFE)
    else $error("reset low did not force fail-safe");
  bat_uv_a: assert property (@(posedge mclk) disable iff (!resetn) // R21
    buv |=> !bus_oe) else $error("bus driven under battery undervoltage");
  uv_reset_a: assert property (@(posedge mclk) disable iff (!resetn) // R15
    $rose(uv_trip) |=> !reset_out_n) else $error("reset not asserted after debounce");
endmodule

// ---- hdl/lintmc_pkg.sv ----
// constants, field layout and mode type for the lin mode controller
package lintmc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int DOM_TIMEOUT_US = 6000;
  localparam int DOM_CYC = DOM_TIMEOUT_US * CLK_MHZ;
  localparam int TX_REARM_US = 10;
  localparam int TX_REARM_CYC = TX_REARM_US * CLK_MHZ;
  localparam int WAKE_FILTER_US = 90;
  localparam int WAKE_CYC = WAKE_FILTER_US * CLK_MHZ;
  localparam int UV_DEBOUNCE_NS = 2000;
  localparam int UV_DEBOUNCE_CYC = (UV_DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HOLD_US = 4000;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  localparam int SLEEP_LEAD_NS = 3200;
  localparam int MODE_WIN_NS = 4000;
  localparam int MODE_WIN_CYC = (MODE_WIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 20;
  localparam int WORD_W = 7;
  localparam int F_OPREQ = 0;
  localparam int F_TX = 1;
  localparam int F_BUS = 2;
  localparam int F_VCC_UV = 3;
  localparam int F_VCC_GOOD = 4;
  localparam int F_BAT_OFF = 5;
  localparam int F_BAT_UV = 6;
  localparam logic [WORD_W-1:0] PIN_RST = 7'h06;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    ST_UNPOWERED = 3'h0,
    ST_FAILSAFE = 3'h1,
    ST_NORMAL = 3'h2,
    ST_SELECT = 3'h3,
    ST_SILENT = 3'h4,
    ST_SLEEP = 3'h5
  } lintmc_state_t;
endpackage

// ---- hdl/lintmc_stream_if.sv ----
// valid/ready stream between the pin sampler, the buffer and the mode logic
`timescale 1ns/1ps
interface lintmc_stream_if;
  import lintmc_pkg::*;
  logic [WORD_W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [WORD_W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport buffer_side (
    input in_data,
    input in_valid,
    output in_ready,
    output out_data,
    output out_valid,
    input out_ready
  );
  modport user_side (
    output in_data,
    output in_valid,
    input in_ready,
    input out_data,
    input out_valid,
    output out_ready
  );
endinterface

// ---- hdl/lintmc_buffer.sv ----
// two-entry buffer for sampled pin words
`timescale 1ns/1ps
module lintmc_buffer (
  input wire logic mclk,
  input wire logic resetn,
  lintmc_stream_if.buffer_side s
);
  import lintmc_pkg::*;
  logic [WORD_W-1:0] mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign s.in_ready = (count != 2'(BUF_DEPTH));
  assign s.out_valid = (count != 2'h0);
  assign s.out_data = mem[rd_ptr];
  assign push = s.in_valid && s.in_ready;
  assign pop = s.out_valid && s.out_ready;

  genvar i;
  generate
    for (i = 0; i < BUF_DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          mem[i] <= PIN_RST;
        end else if (push && (wr_ptr == 1'(i))) begin
          mem[i] <= s.in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + 2'(push) - 2'(pop));
    end
  end
endmodule

// ---- bench/lintmc_host_model.sv ----
// host microcontroller model driving the mode and transmit pins
`timescale 1ns/1ps
module lintmc_host_model (
  input wire logic mclk,
  input wire logic want_op,
  input wire logic want_tx,
  output logic op_req,
  output logic tx_bit_in
);
  logic [1:0] lag;
  logic op_fall;
  assign op_fall = op_req & ~want_op;
  initial begin
    op_req = 1'b0;
    tx_bit_in = 1'b1;
    lag = 2'h0;
  end
  // pins change on the falling edge, away from the sampling edge
  always @(negedge mclk) begin
    op_req <= want_op;
    lag <= op_fall ? 2'h2 : (lag != 2'h0 ? lag - 2'h1 : 2'h0);
    // tx falls a few cycles after the request, well inside the lead time
    tx_bit_in <= want_tx | op_fall | (lag != 2'h0);
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the lin mode controller
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic want_op = 1'b0;
  logic want_tx = 1'b1;
  logic other_rec = 1'b1;
  logic vcc_uv = 1'b0;
  logic battery_off = 1'b0;
  logic battery_uv = 1'b0;
  logic op_req, tx_bit_in, bus_in, vcc_good;
  logic bus_out, bus_oe, rx_bit_out, reset_out_n, regulator_en;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  // regulator modelled as ideal: good as soon as it is enabled
  assign vcc_good = regulator_en;
  // pulled-up bus, wired-and of our driver and the other node
  assign bus_in = (bus_oe ? bus_out : 1'b1) & other_rec;
  lintmc_host_model host (
    .mclk(mclk),
    .want_op(want_op),
    .want_tx(want_tx),
    .op_req(op_req),
    .tx_bit_in(tx_bit_in)
  );
  // short counts keep the run small
  lintmc_top #(.DOM_CYCLES(40), .WAKE_CYCLES(30), .HOLD_CYCLES(20)) uut (
    .mclk(mclk),
    .resetn(resetn),
    .op_req(op_req),
    .tx_bit_in(tx_bit_in),
    .bus_in(bus_in),
    .vcc_uv(vcc_uv),
    .vcc_good(vcc_good),
    .battery_off(battery_off),
    .battery_uv(battery_uv),
    .bus_out(bus_out),
    .bus_oe(bus_oe),
    .rx_bit_out(rx_bit_out),
    .reset_out_n(reset_out_n),
    .regulator_en(regulator_en)
  );
  task automatic cy(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic t_power;
    cy(12);
    chk(reset_out_n === 1'b0, "rst in reset");
    resetn <= 1'b1;
    want_op <= 1'b1;
    other_rec <= 1'b0;
    cy(8);
    chk(regulator_en === 1'b1, "reg on");
    chk(reset_out_n === 1'b0, "hold");
    chk(rx_bit_out === 1'b1, "req ignored");
    cy(40);
    chk(reset_out_n === 1'b1, "hold end");
    chk(rx_bit_out === 1'b0, "rx dom");
    other_rec <= 1'b1;
    cy(10);
    chk(rx_bit_out === 1'b1, "rx rec");
  endtask
  task automatic t_tx;
    want_tx <= 1'b0;
    // loopback through driver, bus and receive pipeline takes twelve edges
    cy(14);
    chk(bus_oe === 1'b1, "oe on");
    chk(rx_bit_out === 1'b0, "rx loop");
    cy(50);
    chk(bus_oe === 1'b0, "dom timeout");
    want_tx <= 1'b1;
    cy(500);
    want_tx <= 1'b0;
    cy(12);
    chk(bus_oe === 1'b0, "early rearm");
    want_tx <= 1'b1;
    cy(1300);
    want_tx <= 1'b0;
    cy(12);
    chk(bus_oe === 1'b1, "rearm");
    battery_uv <= 1'b1;
    cy(12);
    chk(bus_oe === 1'b0, "bat uv");
    battery_uv <= 1'b0;
    want_tx <= 1'b1;
    cy(12);
    chk(bus_oe === 1'b0, "oe off");
  endtask
  // request back high inside the select window must return to normal at once
  task automatic t_abort;
    want_op <= 1'b0;
    cy(100);
    want_op <= 1'b1;
    want_tx <= 1'b0;
    cy(14);
    chk(bus_oe === 1'b1, "select abort");
    chk(bus_out === 1'b0, "driver data");
    want_tx <= 1'b1;
    cy(12);
    chk(bus_oe === 1'b0, "abort oe off");
  endtask
  task automatic t_silent;
    want_op <= 1'b0;
    cy(600);
    other_rec <= 1'b0;
    cy(10);
    chk(rx_bit_out === 1'b1, "silent rx");
    chk(regulator_en === 1'b1, "silent reg");
    other_rec <= 1'b1;
    cy(10);
    chk(rx_bit_out === 1'b1, "short pulse");
    other_rec <= 1'b0;
    cy(45);
    other_rec <= 1'b1;
    cy(12);
    chk(rx_bit_out === 1'b0, "wake");
    cy(100);
    chk(rx_bit_out === 1'b0, "wake held");
    want_op <= 1'b1;
    cy(12);
    chk(rx_bit_out === 1'b1, "to normal");
  endtask
  task automatic t_sleep;
    want_op <= 1'b0;
    want_tx <= 1'b0;
    // driver must stay off throughout the select window
    for (int i = 0; i < 600; i++) begin
      cy(1);
      chk(bus_oe === 1'b0, "sel oe");
    end
    chk(regulator_en === 1'b0, "sleep reg");
    chk(reset_out_n === 1'b0, "sleep rst");
    chk(rx_bit_out === 1'b0, "sleep rx");
    want_tx <= 1'b1;
    other_rec <= 1'b0;
    cy(45);
    other_rec <= 1'b1;
    cy(12);
    chk(regulator_en === 1'b1, "wake reg");
    chk(rx_bit_out === 1'b0, "wake rx");
    want_op <= 1'b1;
    cy(60);
    chk(rx_bit_out === 1'b1, "wake normal");
    want_op <= 1'b0;
    want_tx <= 1'b0;
    cy(600);
    want_tx <= 1'b1;
    want_op <= 1'b1;
    cy(12);
    chk(regulator_en === 1'b1, "req reg");
    chk(reset_out_n === 1'b0, "req rst");
    cy(60);
    want_tx <= 1'b0;
    cy(12);
    chk(bus_oe === 1'b1, "req normal");
    want_tx <= 1'b1;
    cy(12);
  endtask
  task automatic t_uv;
    vcc_uv <= 1'b1;
    cy(200);
    chk(reset_out_n === 1'b1, "uv early");
    cy(70);
    chk(reset_out_n === 1'b0, "uv rst");
    vcc_uv <= 1'b0;
    other_rec <= 1'b0;
    cy(10);
    chk(rx_bit_out === 1'b1, "uv failsafe");
    other_rec <= 1'b1;
    cy(60);
    chk(reset_out_n === 1'b1, "uv hold");
    other_rec <= 1'b0;
    cy(10);
    chk(rx_bit_out === 1'b0, "uv normal");
    other_rec <= 1'b1;
  endtask
  task automatic t_batt;
    want_op <= 1'b0;
    cy(600);
    battery_off <= 1'b1;
    cy(12);
    chk(regulator_en === 1'b0, "bat reg");
    chk(reset_out_n === 1'b0, "bat rst");
    battery_off <= 1'b0;
    cy(60);
    chk(regulator_en === 1'b1, "bat on");
    other_rec <= 1'b0;
    cy(10);
    chk(rx_bit_out === 1'b1, "bat failsafe");
    other_rec <= 1'b1;
  endtask
  initial begin
    t_power();
    t_tx();
    t_abort();
    t_silent();
    t_sleep();
    t_uv();
    t_batt();
    complete_run();
  end
endmodule
